// ==== rtl/stepper_profile_engine.v ====
// Positioning profile engine: record store, sequencer, ramp and step output.
// Assumes an AHB-Lite master with a single slave and inputs synchronous to core_clk.
//
// Summary of operation
// - Store 32 records: type, distance, direction.
// - Relative moves count from current position.
// - Absolute moves go to setpoint position.
// - Internal homing runs to internal reference.
// - External homing runs to external reference.
// - Stored direction only for relative records.
// - Start at start rate; relative and absolute moves also stop at it.
// - Cruise at configured cruise rate.
// - Ramp gradient 0.1 to 3000 Hz/ms.
// - Round gradient to nearest encodable value.
// - Relative repeats pause, at least 1 ms.
// - Repeat record automatically for count.
// - Reverse option flips direction each call.
// - Chain to next record when done.
// - Linear or sinusoidal ramp per record.
// - Start input latches code, runs record code.
// - Falling start edge clears speed error.
// - Two outputs encode run, ready, error, home.
// - Repeat count 1 to 254, zero continuous.
`timescale 1ns/100ps
`include "profile_engine_consts.vh"

module stepper_profile_engine #(
	parameter MS_CYCLES = `MS_CYCLES
) (
	input  wire        core_clk,
	input  wire        rst,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire        start_in,
	input  wire [3:0]  sel_in,
	input  wire        ext_ref_in,
	input  wire        int_ref_in,
	input  wire        speed_fault_in,
	output reg         step_out,
	output reg         dir_out,
	output reg         state_out1,
	output reg         state_out2
);

	// ------------------------------------------------------------------------
	// States and helpers
	// ------------------------------------------------------------------------
	localparam [5:0] S_IDLE  = 6'h01;
	localparam [5:0] S_LOAD  = 6'h02;
	localparam [5:0] S_PREP  = 6'h04;
	localparam [5:0] S_RUN   = 6'h08;
	localparam [5:0] S_PAUSE = 6'h10;
	localparam [5:0] S_FIN   = 6'h20;
	localparam [31:0] MS_LAST_W = MS_CYCLES - 1;
	localparam [16:0] MS_LAST   = MS_LAST_W[16:0];

	function [31:0] mag;
		input [31:0] v;
		begin
			mag = v[31] ? (32'h00000000 - v) : v;
		end
	endfunction

	// Gradient in tenths of Hz/ms to sixteenths of Hz per ms, nearest value.
	function [15:0] round_gradient;
		input [15:0] g;
		reg   [15:0] c;
		reg   [19:0] t;
		begin
			c = (g < `RAMP_MIN) ? `RAMP_MIN : ((g > `RAMP_MAX) ? `RAMP_MAX : g);
			t = ({4'h0, c} * 20'h00010 + 20'h00005) / `RAMP_UNIT;
			round_gradient = t[15:0];
		end
	endfunction

	// Eighth of the ramp span that the rate has reached.
	function [2:0] ramp_index;
		input [23:0] d;
		input [23:0] span;
		integer      k;
		reg   [23:0] t;
		reg   [2:0]  r;
		begin
			t = 24'h000000;
			r = 3'h0;
			for (k = 1; k < 8; k = k + 1)
			begin
				t = t + (span >> 3);
				r = (d >= t) ? k[2:0] : r;
			end
			ramp_index = r;
		end
	endfunction

	// Half-sine acceleration weights in eighths; the mean weight is about one.
	function [3:0] sine_weight;
		input [2:0] i;
		begin
			case (i)
				3'h0:    sine_weight = 4'h2;
				3'h1:    sine_weight = 4'h7;
				3'h2:    sine_weight = 4'hB;
				3'h3:    sine_weight = 4'hD;
				3'h4:    sine_weight = 4'hD;
				3'h5:    sine_weight = 4'hB;
				3'h6:    sine_weight = 4'h7;
				default: sine_weight = 4'h2;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	reg  [5:0]  state_q;
	reg  [4:0]  rec_q;
	reg  [31:0] cfg_q;
	reg  [31:0] dist_q;
	reg  [23:0] vst_q;
	reg  [23:0] vcr_q;
	reg  [15:0] inc_q;
	reg  [15:0] pause_q;
	reg  [7:0]  reps_q;
	reg  [31:0] rem_q;
	reg  [31:0] acc_steps_q;
	reg  [23:0] rate_q;
	reg  [31:0] pos_q;
	reg  [31:0] flip_q;
	reg         run_dir_q;
	reg         ref_hit_q;
	reg         err_q;
	reg         start_d_q;
	reg  [16:0] ms_cnt_q;
	reg  [15:0] pcnt_q;
	reg  [2:0]  ld_word_q;
	reg  [2:0]  ld_idx_q;
	reg         ld_pend_q;
	reg         bp_q;
	reg         bw_q;
	reg  [11:0] ba_q;

	wire [31:0] mem_rdata;
	wire        gen_step;
	wire [1:0]  op        = cfg_q[`F_OP_LSB +: 2];
	wire        homing    = op[1];
	wire        loop_all  = (cfg_q[`F_REP_LSB +: 8] == 8'h00);
	wire [5:0]  next_rec  = cfg_q[`F_NEXT_LSB +: 6];
	wire        ms_tick   = (ms_cnt_q == MS_LAST);
	wire        acc       = hsel & htrans[1] & hready;
	wire        bus_rd    = acc & ~hwrite & haddr[`REC_WIN_BIT];
	wire        bus_wr    = bp_q & bw_q;
	wire        ctrl_wr   = bus_wr & (ba_q == `REG_CTRL);
	wire        cmd_start = ctrl_wr & hwdata[`C_START];
	wire        cmd_stop  = ctrl_wr & hwdata[`C_STOP];
	wire        in_rise   = start_in & ~start_d_q;
	wire        in_fall   = ~start_in & start_d_q;
	wire        running   = (state_q == S_RUN);
	wire [23:0] cruise    = (vcr_q < vst_q) ? vst_q : vcr_q;
	wire        want_dec  = ~homing & (rem_q <= acc_steps_q + 32'h00000001);
	wire [2:0]  ridx      = ramp_index(rate_q - vst_q, cruise - vst_q);
	wire [19:0] winc      = {4'h0, inc_q} * {16'h0000, sine_weight(ridx)};
	wire [23:0] inc_sh    = cfg_q[`F_SHAPE] ? {7'h00, winc[19:3]} : {8'h00, inc_q};
	wire [23:0] inc_eff   = (inc_sh == 24'h000000) ? 24'h000001 : inc_sh;
	wire [23:0] rate_up   = rate_q + inc_eff;
	wire [23:0] rate_dn   = rate_q - inc_eff;
	wire [31:0] abs_diff  = dist_q - pos_q;
	wire [15:0] pause_eff = (pause_q < `PAUSE_MIN) ? `PAUSE_MIN : pause_q;
	wire        ref_seen  = (op == `OP_HOME_INT) ? int_ref_in : ext_ref_in;
	wire [7:0]  mem_raddr = bus_rd ? haddr[9:2] : {rec_q, ld_word_q};
	wire [31:0] stat_word = {16'h0000, 3'h0, rec_q, 1'b0, ref_hit_q, err_q,
	                         state_q[4:0]};

	// ------------------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------------------
	record_memory u_mem (
		.clk   (core_clk),
		.we    (bus_wr & ba_q[`REC_WIN_BIT]),
		.waddr (ba_q[9:2]),
		.wdata (hwdata),
		.raddr (mem_raddr),
		.rdata (mem_rdata)
	);

	step_rate_gen u_gen (
		.core_clk (core_clk),
		.rst      (rst),
		.run      (running),
		.rate     (rate_q),
		.step     (gen_step)
	);

	// ------------------------------------------------------------------------
	// Bus slave: every access takes one wait state.
	// ------------------------------------------------------------------------
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			bp_q      <= 1'b0;
			bw_q      <= 1'b0;
			ba_q      <= 12'h000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h00000000;
		end
		else
		begin
			bp_q      <= acc;
			hreadyout <= ~acc;
			if (acc)
			begin
				bw_q <= hwrite;
				ba_q <= haddr[11:0];
			end
			if (bp_q && !bw_q)
			begin
				if (ba_q[`REC_WIN_BIT])
					hrdata <= mem_rdata;
				else
					case (ba_q)
						`REG_STATUS: hrdata <= stat_word;
						`REG_POS:    hrdata <= pos_q;
						`REG_RATE:   hrdata <= {8'h00, rate_q};
						default:     hrdata <= 32'h00000000;
					endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// Millisecond time base, restarted when a move or pause begins.
	// ------------------------------------------------------------------------
	always @(posedge core_clk)
	begin
		if (rst || state_q == S_PREP || state_q == S_FIN || ms_tick)
			ms_cnt_q <= 17'h00000;
		else
			ms_cnt_q <= ms_cnt_q + 17'h00001;
	end

	// ------------------------------------------------------------------------
	// Error latch and outputs
	// ------------------------------------------------------------------------
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			err_q     <= 1'b0;
			start_d_q <= 1'b0;
		end
		else
		begin
			start_d_q <= start_in;
			if (in_fall)
				err_q <= 1'b0;
			if (speed_fault_in || (running && !homing && ext_ref_in))
				err_q <= 1'b1;
		end
	end

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			step_out   <= 1'b0;
			dir_out    <= 1'b0;
			state_out1 <= 1'b1;
			state_out2 <= 1'b0;
		end
		else
		begin
			step_out <= gen_step & running;
			dir_out  <= run_dir_q;
			if (err_q)
			begin
				state_out1 <= 1'b0;
				state_out2 <= 1'b0;
			end
			else if (state_q != S_IDLE)
			begin
				state_out1 <= 1'b0;
				state_out2 <= 1'b1;
			end
			else
			begin
				state_out1 <= 1'b1;
				state_out2 <= ref_hit_q;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------------
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			state_q     <= S_IDLE;
			rec_q       <= 5'h00;
			cfg_q       <= 32'h00000000;
			dist_q      <= 32'h00000000;
			vst_q       <= 24'h000000;
			vcr_q       <= 24'h000000;
			inc_q       <= 16'h0000;
			pause_q     <= 16'h0000;
			reps_q      <= 8'h00;
			rem_q       <= 32'h00000000;
			acc_steps_q <= 32'h00000000;
			rate_q      <= 24'h000000;
			pos_q       <= `POS_RST;
			flip_q      <= 32'h00000000;
			run_dir_q   <= 1'b0;
			ref_hit_q   <= 1'b0;
			pcnt_q      <= 16'h0000;
			ld_word_q   <= 3'h0;
			ld_idx_q    <= 3'h0;
			ld_pend_q   <= 1'b0;
		end
		else
		begin
			ld_pend_q <= 1'b0;
			if (bus_wr && ba_q == `REG_POS && state_q == S_IDLE)
				pos_q <= hwdata;
			case (state_q)
				S_IDLE:
				begin
					ld_word_q <= 3'h0;
					if (cmd_start && !err_q)
					begin
						rec_q     <= hwdata[`C_REC_LSB +: 5];
						ref_hit_q <= 1'b0;
						state_q   <= S_LOAD;
					end
					else if (in_rise && !err_q)
					begin
						rec_q     <= {1'b0, sel_in};
						ref_hit_q <= 1'b0;
						state_q   <= S_LOAD;
					end
				end
				S_LOAD:
				begin
					if (!bus_rd && ld_word_q != `REC_WORDS)
					begin
						ld_pend_q <= 1'b1;
						ld_idx_q  <= ld_word_q;
						ld_word_q <= ld_word_q + 3'h1;
					end
					if (ld_pend_q)
					begin
						case (ld_idx_q)
							`W_CFG:
							begin
								cfg_q  <= mem_rdata;
								reps_q <= (mem_rdata[`F_REP_LSB +: 8] > `REP_MAX) ?
								          `REP_MAX : mem_rdata[`F_REP_LSB +: 8];
							end
							`W_DIST:    dist_q  <= mem_rdata;
							`W_VSTART:  vst_q   <= {mem_rdata[19:0], 4'h0};
							`W_VCRUISE: vcr_q   <= {mem_rdata[19:0], 4'h0};
							`W_RAMP:    inc_q   <= round_gradient(mem_rdata[15:0]);
							default:    pause_q <= mem_rdata[15:0];
						endcase
						if (ld_idx_q == `W_PAUSE)
							state_q <= S_PREP;
					end
				end
				S_PREP:
				begin
					rate_q      <= vst_q;
					acc_steps_q <= 32'h00000000;
					if (op == `OP_ABS)
					begin
						run_dir_q <= abs_diff[31];
						rem_q     <= mag(abs_diff);
					end
					else if (homing)
					begin
						run_dir_q <= 1'b1;
						rem_q     <= 32'h00000000;
					end
					else
					begin
						run_dir_q <= cfg_q[`F_DIR] ^ (cfg_q[`F_REV] & flip_q[rec_q]);
						rem_q     <= mag(dist_q);
						if (cfg_q[`F_REV])
							flip_q[rec_q] <= ~flip_q[rec_q];
					end
					if (op == `OP_ABS && abs_diff == 32'h00000000)
						state_q <= S_FIN;
					else if (op == `OP_REL && dist_q == 32'h00000000)
						state_q <= S_FIN;
					else
						state_q <= S_RUN;
				end
				S_RUN:
				begin
					if (gen_step)
					begin
						pos_q <= run_dir_q ? pos_q - 32'h00000001 : pos_q + 32'h00000001;
						if (!homing)
							rem_q <= rem_q - 32'h00000001;
						if (!want_dec && rate_q < cruise)
							acc_steps_q <= acc_steps_q + 32'h00000001;
					end
					if (ms_tick)
					begin
						if (want_dec)
							rate_q <= (rate_dn < vst_q || rate_dn > rate_q) ? vst_q : rate_dn;
						else if (rate_q < cruise)
							rate_q <= (rate_up > cruise) ? cruise : rate_up;
					end
					if (cmd_stop || speed_fault_in)
						state_q <= S_IDLE;
					else if (homing && ref_seen)
					begin
						pos_q     <= `POS_RST;
						ref_hit_q <= 1'b1;
						state_q   <= S_IDLE;
					end
					else if (!homing && ext_ref_in)
						state_q <= S_IDLE;
					else if (gen_step && !homing && rem_q == 32'h00000001)
						state_q <= S_FIN;
				end
				S_PAUSE:
				begin
					if (ms_tick)
						pcnt_q <= pcnt_q + 16'h0001;
					if (cmd_stop)
						state_q <= S_IDLE;
					else if (ms_tick && pcnt_q + 16'h0001 >= pause_eff)
						state_q <= S_PREP;
				end
				S_FIN:
				begin
					pcnt_q <= 16'h0000;
					if (cmd_stop)
						state_q <= S_IDLE;
					else if (loop_all || reps_q > 8'h01)
					begin
						if (!loop_all)
							reps_q <= reps_q - 8'h01;
						state_q <= (op == `OP_REL) ? S_PAUSE : S_PREP;
					end
					else if (next_rec != 6'h00)
					begin
						rec_q     <= next_rec[4:0] - 5'h01;
						ld_word_q <= 3'h0;
						state_q   <= S_LOAD;
					end
					else
						state_q <= S_IDLE;
				end
				default:
					state_q <= S_IDLE;
			endcase
		end
	end

endmodule // stepper_profile_engine

// ==== common/profile_engine_consts.vh ====
// Constants of the positioning profile engine: timing, bus offsets, record layout.
// Assumes a single 100 MHz clock; included by the engine, the step generator and the testbench.
`ifndef PROFILE_ENGINE_CONSTS_VH
`define PROFILE_ENGINE_CONSTS_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS  10
`define CLK_HZ         100000000
`define MS_TIME_NS     1000000
`define MS_CYCLES      (`MS_TIME_NS / `CLK_PERIOD_NS)
`define RATE_FRAC      16

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define REG_CTRL       12'h000
`define REG_STATUS     12'h004
`define REG_POS        12'h008
`define REG_RATE       12'h00C
`define REC_WIN_BIT    10

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define C_START        0
`define C_STOP         1
`define C_REC_LSB      8

// ----------------------------------------------------------------------------
// Record words and fields
// ----------------------------------------------------------------------------
`define NUM_RECORDS    32
`define W_CFG          3'h0
`define W_DIST         3'h1
`define W_VSTART       3'h2
`define W_VCRUISE      3'h3
`define W_RAMP         3'h4
`define W_PAUSE        3'h5
`define REC_WORDS      3'h6
`define F_OP_LSB       0
`define F_DIR          2
`define F_REV          3
`define F_SHAPE        4
`define F_NEXT_LSB     8
`define F_REP_LSB      16
`define OP_REL         2'h0
`define OP_ABS         2'h1
`define OP_HOME_INT    2'h2
`define OP_HOME_EXT    2'h3

// ----------------------------------------------------------------------------
// Limits and reset values
// ----------------------------------------------------------------------------
`define RAMP_MIN       16'h0001
`define RAMP_MAX       16'h7530
`define RAMP_UNIT      20'h0000A
`define PAUSE_MIN      16'h0001
`define REP_MAX        8'hFE
`define POS_RST        32'h00000000

`endif

// ==== rtl/record_memory.v ====
// Record store: 32 records of eight 32-bit words, one write and one read port.
// Assumes one clock; read data appear one cycle after the address.
`timescale 1ns/100ps

module record_memory (
	input  wire        clk,
	input  wire        we,
	input  wire [7:0]  waddr,
	input  wire [31:0] wdata,
	input  wire [7:0]  raddr,
	output reg  [31:0] rdata
);

	reg [31:0] mem [0:255];

	always @(posedge clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end

endmodule // record_memory

// ==== rtl/step_rate_gen.v ====
// Step pulse generator: a phase accumulator turning a rate into step pulses.
// Assumes the rate in sixteenths of a hertz and the 100 MHz core clock.
`timescale 1ns/100ps
`include "profile_engine_consts.vh"

module step_rate_gen (
	input  wire        core_clk,
	input  wire        rst,
	input  wire        run,
	input  wire [23:0] rate,
	output reg         step
);

	localparam [31:0] FULL = `CLK_HZ * `RATE_FRAC;

	reg  [31:0] acc_q;
	wire [31:0] sum = acc_q + {8'h00, rate};

	always @(posedge core_clk)
	begin
		if (rst || !run)
		begin
			acc_q <= 32'h00000000;
			step  <= 1'b0;
		end
		else if (sum >= FULL)
		begin
			acc_q <= sum - FULL;
			step  <= 1'b1;
		end
		else
		begin
			acc_q <= sum;
			step  <= 1'b0;
		end
	end

endmodule // step_rate_gen

// ==== verification/step_stage_model.sv ====
// Power stage model: counts step pulses, tracks position, raises references.
// Assumes step_out is a one-cycle pulse and dir_out high means left.
`timescale 1ns/100ps

module step_stage_model (
	input  wire logic               core_clk,
	input  wire logic               rst,
	input  wire logic               step_out,
	input  wire logic               dir_out,
	input  wire logic               clr,
	input  wire logic [1:0]         ref_en,
	input  wire logic signed [31:0] ref_at,
	output logic                    int_ref_in,
	output logic                    ext_ref_in,
	output logic signed [31:0]      pos,
	output logic [31:0]             steps,
	output logic [31:0]             max_gap
);
	logic [31:0] gap_q;

	// Reference switches close once the shaft is at or left of ref_at.
	assign int_ref_in = ref_en[0] && (pos <= ref_at);
	assign ext_ref_in = ref_en[1] && (pos <= ref_at);

	always @(posedge core_clk)
	begin
		if (rst || clr)
		begin
			gap_q <= 32'h0;
			max_gap <= 32'h0;
		end
		else
		begin
			gap_q <= step_out ? 32'h0 : gap_q + 32'h1;
			if (step_out && gap_q > max_gap)
				max_gap <= gap_q;
		end
		if (rst)
		begin
			pos <= 32'h0;
			steps <= 32'h0;
		end
		else if (step_out)
		begin
			steps <= steps + 32'h1;
			pos <= dir_out ? pos - 32'h1 : pos + 32'h1;
		end
	end
endmodule // step_stage_model

// ==== verification/stepper_profile_engine_chk.sv ====
// Port checker of the profile engine: bus handshake, step pulses, state code.
// Assumes binding to stepper_profile_engine with one clock and synchronous reset.
`timescale 1ns/100ps

module stepper_profile_engine_chk #(
	parameter MS_CYCLES = 20
) (
	input wire       core_clk,
	input wire       rst,
	input wire       hsel,
	input wire [1:0] htrans,
	input wire       hready,
	input wire       hreadyout,
	input wire       hresp,
	input wire       start_in,
	input wire       speed_fault_in,
	input wire       ext_ref_in,
	input wire       step_out,
	input wire       state_out1,
	input wire       state_out2
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	wire take = hsel && htrans[1] && hready;

	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("hresp not OKAY");
	chk_bus_wait: assert property (take |=> !hreadyout ##1 hreadyout)
		else $error("data phase not one wait state");
	chk_wait_cause: assert property (!hreadyout |-> $past(take))
		else $error("wait state without transfer");
	chk_step_pulse: assert property (step_out |=> !step_out)
		else $error("step pulse longer than one cycle");
	chk_step_running: assert property (step_out |-> !state_out1 && state_out2)
		else $error("step while not running");
	chk_idle_quiet: assert property (state_out1 && $past(state_out1) |-> !step_out)
		else $error("step while idle");
	chk_start_taken: assert property ($rose(start_in) && !$past(rst) && state_out1
		&& !speed_fault_in && !$past(speed_fault_in) && !ext_ref_in
		|-> ##2 (!state_out1 && state_out2))
		else $error("start not taken");
	chk_fault_error: assert property (speed_fault_in |-> ##[1:2] (!state_out1 && !state_out2))
		else $error("fault not shown");
	chk_error_clear: assert property ($fell(start_in) && !state_out1 && !state_out2
		&& !speed_fault_in && !ext_ref_in |-> ##[1:3] (state_out1 && !state_out2))
		else $error("error not cleared");
endmodule // stepper_profile_engine_chk

bind stepper_profile_engine stepper_profile_engine_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (
	.core_clk(core_clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .start_in(start_in),
	.speed_fault_in(speed_fault_in), .ext_ref_in(ext_ref_in), .step_out(step_out),
	.state_out1(state_out1), .state_out2(state_out2));

// ==== verification/stepper_positioning_profile_engine_tb_top.sv ====
// Testbench of the profile engine: AHB-Lite master, start pins, power stage model.
// Assumes the engine with a shortened millisecond and fast step rates.
`timescale 1ns/100ps
`include "profile_engine_consts.vh"

module stepper_positioning_profile_engine_tb_top;
	localparam MSC = 500;
	logic               core_clk = 0, rst = 1, hsel = 0, hwrite = 0;
	logic               start_in = 0, speed_fault_in = 0, clr = 0, dir;
	logic [31:0]        haddr = 0, hwdata = 0, r, s0, d;
	logic [1:0]         htrans = 0, ref_en = 0;
	logic [3:0]         sel_in = 0, sel;
	logic               rdy_s;
	logic [1:0]         st_s;
	logic signed [31:0] ref_at = 0, exp_pos = 0, p0, t;
	wire [31:0]         hrdata, msteps, max_gap;
	wire signed [31:0]  mpos;
	wire                hreadyout, hresp, step_out, dir_out, state_out1, state_out2;
	wire                int_ref_in, ext_ref_in;
	int                 num_errors = 0, tests_run = 0, i, k;
	integer             seed = 32'h1aec;

	always #5 core_clk = ~core_clk;

	// Outputs settle mid-cycle; these copies are what the next rising edge sees.
	always @(negedge core_clk)
	begin
		rdy_s = hreadyout;
		st_s = {state_out1, state_out2};
	end

	stepper_profile_engine #(.MS_CYCLES(MSC)) i_dut (.core_clk(core_clk), .rst(rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .start_in(start_in), .sel_in(sel_in), .ext_ref_in(ext_ref_in),
		.int_ref_in(int_ref_in), .speed_fault_in(speed_fault_in), .step_out(step_out),
		.dir_out(dir_out), .state_out1(state_out1), .state_out2(state_out2));
	step_stage_model i_stage (.core_clk(core_clk), .rst(rst), .step_out(step_out),
		.dir_out(dir_out), .clr(clr), .ref_en(ref_en), .ref_at(ref_at),
		.int_ref_in(int_ref_in), .ext_ref_in(ext_ref_in), .pos(mpos), .steps(msteps),
		.max_gap(max_gap));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task stop_test;
		$display("errors %0d of %0d checks", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Single word transfer; entered right after a rising edge.
	task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge core_clk);
		while (rdy_s !== 1'b1) @(posedge core_clk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge core_clk);
		while (rdy_s !== 1'b1) @(posedge core_clk);
		r = hrdata;
	endtask

	function logic [31:0] cfg(input logic [1:0] op, input logic dr, rv, sh,
		input logic [5:0] nx, input logic [7:0] rp);
		cfg = (op << `F_OP_LSB) | (dr << `F_DIR) | (rv << `F_REV) | (sh << `F_SHAPE)
			| (nx << `F_NEXT_LSB) | (rp << `F_REP_LSB);
	endfunction

	// All six words; the ramp is random over the full field to reach the clamps.
	task prog(input logic [4:0] rec, input logic [31:0] c, input logic [31:0] dst);
		logic [31:0] w [6];
		w = '{c, dst, 32'h0007A120, 32'h000F4240, {$random(seed)} % 32'h10000, 32'h1};
		for (k = 0; k < 6; k++)
			bus(1, 32'h400 + {rec, 5'h0} + k * 4, w[k]);
	endtask

	task go(input logic by_bus, input logic [4:0] rec);
		s0 = msteps;
		p0 = mpos;
		clr <= 1;
		if (by_bus)
			bus(1, `REG_CTRL, {rec, 8'h01});
		else
		begin
			sel_in <= rec[3:0];
			start_in <= 1;
			@(posedge core_clk);
		end
		clr <= 0;
		for (i = 0; i < 20 && st_s[1] !== 1'b0; i++) @(posedge core_clk);
		start_in <= 0;
		for (i = 0; i < 40000 && st_s[1] !== 1'b1; i++) @(posedge core_clk);
		chk(st_s[1], 1);
	endtask

	initial
	begin
		repeat (12) @(posedge core_clk);
		rst <= 0;
		@(posedge core_clk);
		chk(st_s, 2'b10);
		bus(0, `REG_STATUS, 0);
		chk(r, 32'h1);
		bus(0, `REG_POS, 0);
		chk(r, `POS_RST);
		bus(1, 32'h100, 32'hFFFFFFFF);
		bus(0, 32'h100, 0);
		chk(r, 0);
		sel = $random(seed);
		dir = $random(seed);
		d = 5 + {$random(seed)} % 8;
		prog({1'b0, sel}, cfg(`OP_REL, dir, 0, 0, 0, 1), d);
		go(0, {1'b0, sel});
		chk(msteps - s0, d);
		chk(mpos - p0, dir ? -d : d);
		exp_pos = exp_pos + (dir ? -d : d);
		bus(0, `REG_POS, 0);
		chk(r, exp_pos);
		t = $random(seed) % 20 - 40;
		prog(16, cfg(`OP_ABS, 0, 0, 0, 0, 1), t);
		go(1, 16);
		chk(msteps - s0, exp_pos - t);
		chk(mpos - p0, t - exp_pos);
		exp_pos = t;
		bus(0, `REG_POS, 0);
		chk(r, exp_pos);
		prog(2, cfg(`OP_REL, 1, 1, 0, 0, 3), 4);
		go(0, 2);
		chk(msteps - s0, 12);
		chk(mpos - p0, 32'hFFFFFFFC);
		chk(max_gap >= MSC, 1);
		exp_pos = exp_pos + mpos - p0;
		prog(3, cfg(`OP_REL, 0, 0, 0, 5, 1), 3);
		prog(4, cfg(`OP_REL, 0, 0, 1, 0, 1), 2);
		go(0, 3);
		chk(msteps - s0, 5);
		chk(mpos - p0, 5);
		speed_fault_in <= 1;
		@(posedge core_clk);
		speed_fault_in <= 0;
		repeat (3) @(posedge core_clk);
		chk(st_s, 2'b00);
		start_in <= 1;
		repeat (4) @(posedge core_clk);
		chk(st_s, 2'b00);
		start_in <= 0;
		repeat (4) @(posedge core_clk);
		chk(st_s, 2'b10);
		for (int h = 0; h < 2; h++)
		begin
			prog(5, cfg(h ? `OP_HOME_EXT : `OP_HOME_INT, 0, 0, 0, 0, 1), 0);
			ref_at <= mpos - 3;
			ref_en <= h ? 2'b10 : 2'b01;
			go(0, 5);
			chk(st_s, 2'b11);
			chk(p0 - mpos, 3);
			bus(0, `REG_POS, 0);
			chk(r, 0);
			ref_en <= 0;
		end
		stop_test;
	end

	initial
	begin
		repeat (90000) @(posedge core_clk);
		num_errors++;
		stop_test;
	end
endmodule // stepper_positioning_profile_engine_tb_top
